/* include/arts_regs.svh */
// Register offsets, field positions, codes and timing figures of the
// automatic-retry transmit sequencer.
// Assumes an 8-bit register port with 6-bit addresses.
`ifndef ARTS_REGS_SVH
`define ARTS_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ARTS_ADDR_STATUS 6'h01
`define ARTS_ADDR_STATE 6'h02
`define ARTS_ADDR_CTRL1 6'h04
`define ARTS_ADDR_CCAMODE 6'h08
`define ARTS_ADDR_THRES 6'h09
`define ARTS_ADDR_MASK 6'h0e
`define ARTS_ADDR_AACKCTL 6'h17
`define ARTS_ADDR_RETRY 6'h2c
`define ARTS_ADDR_SEED0 6'h2d
`define ARTS_ADDR_SEED1 6'h2e
`define ARTS_ADDR_BE 6'h2f

// ****************************************************************
// Reset values
// ****************************************************************
`define ARTS_RST_ZERO 8'h00
`define ARTS_RST_CTRL1 8'h20
`define ARTS_RST_RETRY 8'h38

// ****************************************************************
// Field positions
// ****************************************************************
`define ARTS_CMD_MSB 4
`define ARTS_FRMRETRY_MSB 7
`define ARTS_FRMRETRY_LSB 4
`define ARTS_CSMARETRY_MSB 3
`define ARTS_CSMARETRY_LSB 1
`define ARTS_MAXBE_MSB 7
`define ARTS_MAXBE_LSB 4
`define ARTS_MINBE_MSB 3
`define ARTS_MINBE_LSB 0
`define ARTS_SEEDHI_MSB 2
`define ARTS_ACKREQ_BIT 5
`define ARTS_LEN_MSB 6
`define ARTS_IRQ_RXSTART 2
`define ARTS_IRQ_FRAMEEND 3
`define ARTS_IRQ_CCADONE 4
`define ARTS_IRQ_ADDRMATCH 5

// ****************************************************************
// Frame buffer byte positions
// ****************************************************************
`define ARTS_IDX_PHR 8'h00
`define ARTS_IDX_FCF 8'h01
`define ARTS_IDX_SEQ 8'h03

// ****************************************************************
// Command, state and result codes
// ****************************************************************
`define ARTS_CMD_TXSTART 5'h02
`define ARTS_CMD_FORCEOFF 5'h03
`define ARTS_CMD_OFF 5'h08
`define ARTS_CMD_ARETON 5'h19
`define ARTS_STS_OFF 5'h08
`define ARTS_STS_ARETON 5'h19
`define ARTS_STS_ARETBUSY 5'h12
`define ARTS_RES_OK 3'h0
`define ARTS_RES_PENDING 3'h1
`define ARTS_RES_WAITACK 3'h2
`define ARTS_RES_CHANBUSY 3'h3
`define ARTS_RES_NOACK 3'h5
`define ARTS_RES_INVALID 3'h7
`define ARTS_CSMA_IMMEDIATE 3'h7

// ****************************************************************
// Timing, in symbol periods and nanoseconds
// ****************************************************************
`define ARTS_ACKWAIT_BPSK 16'h0078
`define ARTS_ACKWAIT_OQPSK 16'h0036
`define ARTS_CCA_SYMS 16'h0008
`define ARTS_UNIT_BACKOFF 16'h0014
`define ARTS_CLK_NS 20
`define ARTS_SYM_NS_BPSK 50000
`define ARTS_SYM_NS_OQPSK 16000

`endif

/* include/arts_pkg.sv */
// Types shared by the automatic-retry transmit sequencer.
// Assumes arts_regs.svh for the numeric constants.
package arts_pkg;

  typedef enum logic [2:0] {
    ARTS_OFF = 3'h0,
    ARTS_IDLE = 3'h1,
    ARTS_BACKOFF = 3'h3,
    ARTS_CCA = 3'h2,
    ARTS_TX = 3'h6,
    ARTS_ACKWAIT = 3'h7
  } arts_state_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [5:0] addr;
    logic [7:0] wdata;
  } arts_bus_t;

  typedef struct packed {
    logic done;
    logic fcsOk;
    logic isAck;
    logic filterMatch;
    logic pending;
    logic [7:0] seq;
  } arts_rx_t;

  typedef struct packed {
    logic rxStart;
    logic addrMatch;
    logic ccaEdDone;
  } arts_ev_t;

endpackage

/* verilog/arts_sequencer.sv */
// Automatic-retry transmit sequencer with CSMA-CA, ACK wait and retries.
// Assumes a register port from the serial interface engine, a frame
// buffer read port with data valid while fbRead is high, a CCA unit and
// a receiver that reports finished frames.
//
// Functional notes
// - Command 0x19 enters retry mode, awaits start.
// - Start runs CSMA-CA, then sends buffered frame.
// - Start from trigger rising edge or command.
// - Busy beyond retry limit reports result 3.
// - Ack request bit 5 of header decides.
// - No ack requested: end with result 0.
// - Accept ACK only with matching sequence, good FCS.
// - Valid ACK gives 0 or 1 by pending.
// - Timeouts beyond frame limit report result 5.
// - Result reads 7 from entry until end or ACK wait.
// - Channel limit 7: one immediate transmission.
// - ACK reception never writes the frame buffer.
// - Unexpected frames during ACK wait are dropped.
// - ACK timeout 120 or 54 symbols.
// - CCA lasts 8 symbols; zero exponent, zero backoff.
// - Result shows awaiting-reply during ACK wait.
// - Status busy during transaction, idle after.
// - Interrupts reach output only when enabled.
// - Reception start event forwarded after header.
// - Auto-ack receive end needs match and FCS.
// - Suppress CCA done; rx start, match in wait.
// - Frame retry limit is bits 7:4.
// - Command write starts transition; 0x19 idle state.
`timescale 1ns/10ps
`include "arts_regs.svh"

module arts_sequencer #(
  parameter logic [15:0] SymCyclesBpsk =
    16'(`ARTS_SYM_NS_BPSK / `ARTS_CLK_NS),
  parameter logic [15:0] SymCyclesOqpsk =
    16'(`ARTS_SYM_NS_OQPSK / `ARTS_CLK_NS)
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire arts_pkg::arts_bus_t bus,
  output logic [7:0] regRdata,
  input wire logic sleepTrigger,
  input wire logic oqpskMode,
  input wire logic aackMode,
  output logic ccaRun,
  input wire logic ccaIdle,
  output logic fbRead,
  output logic [7:0] fbAddr,
  input wire logic [7:0] fbData,
  output logic [7:0] txData,
  output logic txValid,
  input wire logic txReady,
  output logic rxOn,
  input wire arts_pkg::arts_rx_t rx,
  input wire arts_pkg::arts_ev_t ev,
  output logic [7:0] irqCause,
  output logic irqLine
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic [15:0] lfsrStep(input logic [15:0] v);
    lfsrStep = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // A zero exponent masks every bit, so the backoff has zero length.
  function automatic logic [15:0] backoffSyms(input logic [15:0] rnd,
                                              input logic [3:0] be);
    logic [8:0] mask;
    logic [3:0] e;
    e = (be > 4'h8) ? 4'h8 : be;
    mask = (9'h001 << e) - 9'h001;
    backoffSyms = {8'h00, rnd[7:0] & mask[7:0]} * `ARTS_UNIT_BACKOFF;
  endfunction

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [7:0] ctrl1_r, ctrl1_nxt, ccaMode_r, ccaMode_nxt;
  logic [7:0] thres_r, thres_nxt, mask_r, mask_nxt;
  logic [7:0] aackCtl_r, aackCtl_nxt, retry_r, retry_nxt;
  logic [7:0] seed0_r, seed0_nxt, seed1_r, seed1_nxt, beCfg_r, beCfg_nxt;
  logic [4:0] cmd_r, cmd_nxt;
  logic [7:0] rdData_r, rdData_nxt;
  logic [2:0] result_r;
  logic [4:0] stsCode;
  arts_pkg::arts_state_t st_r;

  always_comb
  begin
    ctrl1_nxt = ctrl1_r;
    ccaMode_nxt = ccaMode_r;
    thres_nxt = thres_r;
    mask_nxt = mask_r;
    aackCtl_nxt = aackCtl_r;
    retry_nxt = retry_r;
    seed0_nxt = seed0_r;
    seed1_nxt = seed1_r;
    beCfg_nxt = beCfg_r;
    cmd_nxt = cmd_r;
    rdData_nxt = rdData_r;
    if (st_r == arts_pkg::ARTS_OFF)
      stsCode = `ARTS_STS_OFF;
    else if (st_r == arts_pkg::ARTS_IDLE)
      stsCode = `ARTS_STS_ARETON;
    else
      stsCode = `ARTS_STS_ARETBUSY;
    if (bus.we)
    begin
      if (bus.addr == `ARTS_ADDR_STATE)
        cmd_nxt = bus.wdata[`ARTS_CMD_MSB:0];
      else if (bus.addr == `ARTS_ADDR_CTRL1)
        ctrl1_nxt = bus.wdata;
      else if (bus.addr == `ARTS_ADDR_CCAMODE)
        ccaMode_nxt = bus.wdata;
      else if (bus.addr == `ARTS_ADDR_THRES)
        thres_nxt = bus.wdata;
      else if (bus.addr == `ARTS_ADDR_MASK)
        mask_nxt = bus.wdata;
      else if (bus.addr == `ARTS_ADDR_AACKCTL)
        aackCtl_nxt = bus.wdata;
      else if (bus.addr == `ARTS_ADDR_RETRY)
        retry_nxt = bus.wdata;
      else if (bus.addr == `ARTS_ADDR_SEED0)
        seed0_nxt = bus.wdata;
      else if (bus.addr == `ARTS_ADDR_SEED1)
        seed1_nxt = bus.wdata;
      else if (bus.addr == `ARTS_ADDR_BE)
        beCfg_nxt = bus.wdata;
    end
    if (bus.re)
    begin
      // CCA flags in the status register are not updated in this mode.
      if (bus.addr == `ARTS_ADDR_STATUS)
        rdData_nxt = {3'h0, stsCode};
      else if (bus.addr == `ARTS_ADDR_STATE)
        rdData_nxt = {result_r, cmd_r};
      else if (bus.addr == `ARTS_ADDR_CTRL1)
        rdData_nxt = ctrl1_r;
      else if (bus.addr == `ARTS_ADDR_CCAMODE)
        rdData_nxt = ccaMode_r;
      else if (bus.addr == `ARTS_ADDR_THRES)
        rdData_nxt = thres_r;
      else if (bus.addr == `ARTS_ADDR_MASK)
        rdData_nxt = mask_r;
      else if (bus.addr == `ARTS_ADDR_AACKCTL)
        rdData_nxt = aackCtl_r;
      else if (bus.addr == `ARTS_ADDR_RETRY)
        rdData_nxt = retry_r;
      else if (bus.addr == `ARTS_ADDR_SEED0)
        rdData_nxt = seed0_r;
      else if (bus.addr == `ARTS_ADDR_SEED1)
        rdData_nxt = seed1_r;
      else if (bus.addr == `ARTS_ADDR_BE)
        rdData_nxt = beCfg_r;
      else
        rdData_nxt = `ARTS_RST_ZERO;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl1_r <= `ARTS_RST_CTRL1;
      ccaMode_r <= `ARTS_RST_ZERO;
      thres_r <= `ARTS_RST_ZERO;
      mask_r <= `ARTS_RST_ZERO;
      aackCtl_r <= `ARTS_RST_ZERO;
      retry_r <= `ARTS_RST_RETRY;
      seed0_r <= `ARTS_RST_ZERO;
      seed1_r <= `ARTS_RST_ZERO;
      beCfg_r <= `ARTS_RST_ZERO;
      cmd_r <= 5'h00;
      rdData_r <= `ARTS_RST_ZERO;
    end
    else if (ce)
    begin
      ctrl1_r <= ctrl1_nxt;
      ccaMode_r <= ccaMode_nxt;
      thres_r <= thres_nxt;
      mask_r <= mask_nxt;
      aackCtl_r <= aackCtl_nxt;
      retry_r <= retry_nxt;
      seed0_r <= seed0_nxt;
      seed1_r <= seed1_nxt;
      beCfg_r <= beCfg_nxt;
      cmd_r <= cmd_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  assign regRdata = rdData_r;

  // ****************************************************************
  // Transaction sequencer, transmit buffer and interrupts
  // ****************************************************************
  arts_pkg::arts_state_t st_nxt;
  logic [2:0] result_nxt, nb_r, nb_nxt;
  logic [3:0] be_r, be_nxt, fr_r, fr_nxt;
  logic [15:0] symDiv_r, symDiv_nxt, symLeft_r, symLeft_nxt;
  logic [15:0] lfsr_r, lfsr_nxt, symTop;
  logic [7:0] fetchIdx_r, fetchIdx_nxt, fbAddr_r, fbAddr_nxt;
  logic [7:0] sentCnt_r, sentCnt_nxt, len_r, len_nxt;
  logic [7:0] fcf_r, fcf_nxt, seq_r, seq_nxt;
  logic [7:0] head_r, head_nxt, tail_r, tail_nxt;
  logic headV_r, headV_nxt, tailV_r, tailV_nxt;
  logic lenKnown_r, lenKnown_nxt, fbRd_r, fbRd_nxt;
  logic trigPrev_r, ccaRun_r, ccaRun_nxt, rxOn_r, rxOn_nxt;
  logic [7:0] irqCause_r, irqCause_nxt, events;
  logic irq_r, irq_nxt, symTick, cmdWr, startEv, pop, immediate;
  logic [3:0] maxBe, minBe;
  logic [1:0] occupancy;

  always_comb
  begin
    st_nxt = st_r;
    result_nxt = result_r;
    nb_nxt = nb_r;
    be_nxt = be_r;
    fr_nxt = fr_r;
    lfsr_nxt = lfsrStep(lfsr_r);
    fetchIdx_nxt = fetchIdx_r;
    fbAddr_nxt = fbAddr_r;
    sentCnt_nxt = sentCnt_r;
    len_nxt = len_r;
    fcf_nxt = fcf_r;
    seq_nxt = seq_r;
    head_nxt = head_r;
    tail_nxt = tail_r;
    headV_nxt = headV_r;
    tailV_nxt = tailV_r;
    lenKnown_nxt = lenKnown_r;
    fbRd_nxt = 1'b0;
    events = 8'h00;
    maxBe = beCfg_r[`ARTS_MAXBE_MSB:`ARTS_MAXBE_LSB];
    minBe = beCfg_r[`ARTS_MINBE_MSB:`ARTS_MINBE_LSB];
    immediate = retry_r[`ARTS_CSMARETRY_MSB:`ARTS_CSMARETRY_LSB] ==
                `ARTS_CSMA_IMMEDIATE;
    cmdWr = bus.we && (bus.addr == `ARTS_ADDR_STATE);
    startEv = (sleepTrigger && !trigPrev_r) ||
              (cmdWr && bus.wdata[`ARTS_CMD_MSB:0] == `ARTS_CMD_TXSTART);
    symTop = oqpskMode ? SymCyclesOqpsk : SymCyclesBpsk;
    symTick = symDiv_r >= symTop - 16'h0001;
    symDiv_nxt = symTick ? 16'h0000 : symDiv_r + 16'h0001;
    symLeft_nxt = symLeft_r;
    if (symTick && symLeft_r != 16'h0000)
      symLeft_nxt = symLeft_r - 16'h0001;

    // Two-entry buffer: head is the output stage, tail absorbs a stall.
    pop = headV_r && txReady;
    if (pop)
    begin
      head_nxt = tail_r;
      headV_nxt = tailV_r;
      tailV_nxt = 1'b0;
      sentCnt_nxt = sentCnt_r + 8'h01;
    end
    // The buffer is only read; nothing here ever writes it.
    if (fbRd_r)
    begin
      if (!headV_nxt)
      begin
        head_nxt = fbData;
        headV_nxt = 1'b1;
      end
      else
      begin
        tail_nxt = fbData;
        tailV_nxt = 1'b1;
      end
      if (fbAddr_r == `ARTS_IDX_PHR)
      begin
        len_nxt = {1'b0, fbData[`ARTS_LEN_MSB:0]};
        lenKnown_nxt = 1'b1;
      end
      else if (fbAddr_r == `ARTS_IDX_FCF)
        fcf_nxt = fbData;
      else if (fbAddr_r == `ARTS_IDX_SEQ)
        seq_nxt = fbData;
    end
    // Reads in flight count as occupied, so a full buffer stops fetching.
    occupancy = {1'b0, headV_r} + {1'b0, tailV_r} + {1'b0, fbRd_r};
    if (st_r == arts_pkg::ARTS_TX && occupancy < 2'h2 &&
        (fetchIdx_r == `ARTS_IDX_PHR ||
         (lenKnown_r && fetchIdx_r <= len_r)))
    begin
      fbRd_nxt = 1'b1;
      fbAddr_nxt = fetchIdx_r;
      fetchIdx_nxt = fetchIdx_r + 8'h01;
    end

    case (st_r)
      arts_pkg::ARTS_OFF:
        if (cmdWr && bus.wdata[`ARTS_CMD_MSB:0] == `ARTS_CMD_ARETON)
        begin
          st_nxt = arts_pkg::ARTS_IDLE;
          result_nxt = `ARTS_RES_INVALID;
        end
      arts_pkg::ARTS_IDLE:
        if (cmdWr && bus.wdata[`ARTS_CMD_MSB:0] == `ARTS_CMD_OFF)
          st_nxt = arts_pkg::ARTS_OFF;
        else if (startEv)
        begin
          nb_nxt = 3'h0;
          fr_nxt = 4'h0;
          be_nxt = minBe;
          result_nxt = `ARTS_RES_INVALID;
          lfsr_nxt = {5'h00, seed1_r[`ARTS_SEEDHI_MSB:0], seed0_r} ^
                     lfsr_r;
          if (immediate)
            st_nxt = arts_pkg::ARTS_TX;
          else
          begin
            st_nxt = arts_pkg::ARTS_BACKOFF;
            symLeft_nxt = backoffSyms(lfsr_r, minBe);
          end
        end
      arts_pkg::ARTS_BACKOFF:
        if (symLeft_r == 16'h0000)
        begin
          st_nxt = arts_pkg::ARTS_CCA;
          symLeft_nxt = `ARTS_CCA_SYMS;
        end
      arts_pkg::ARTS_CCA:
        if (symLeft_r == 16'h0000)
        begin
          if (ccaIdle)
            st_nxt = arts_pkg::ARTS_TX;
          else if (nb_r >= retry_r[`ARTS_CSMARETRY_MSB:`ARTS_CSMARETRY_LSB])
          begin
            st_nxt = arts_pkg::ARTS_IDLE;
            result_nxt = `ARTS_RES_CHANBUSY;
            events[`ARTS_IRQ_FRAMEEND] = 1'b1;
          end
          else
          begin
            nb_nxt = nb_r + 3'h1;
            be_nxt = (be_r < maxBe) ? be_r + 4'h1 : be_r;
            st_nxt = arts_pkg::ARTS_BACKOFF;
            symLeft_nxt = backoffSyms(lfsr_r, be_nxt);
          end
        end
      arts_pkg::ARTS_TX:
        if (lenKnown_r && sentCnt_r == len_r + 8'h01)
        begin
          if (fcf_r[`ARTS_ACKREQ_BIT])
          begin
            st_nxt = arts_pkg::ARTS_ACKWAIT;
            result_nxt = `ARTS_RES_WAITACK;
            symLeft_nxt = oqpskMode ? `ARTS_ACKWAIT_OQPSK :
                                      `ARTS_ACKWAIT_BPSK;
          end
          else
          begin
            st_nxt = arts_pkg::ARTS_IDLE;
            result_nxt = `ARTS_RES_OK;
            events[`ARTS_IRQ_FRAMEEND] = 1'b1;
          end
        end
      arts_pkg::ARTS_ACKWAIT:
        // Anything but the matching ACK falls through unreported.
        if (rx.done && rx.fcsOk && rx.isAck && rx.seq == seq_r)
        begin
          st_nxt = arts_pkg::ARTS_IDLE;
          result_nxt = rx.pending ? `ARTS_RES_PENDING :
                                    `ARTS_RES_OK;
          events[`ARTS_IRQ_FRAMEEND] = 1'b1;
        end
        else if (symLeft_r == 16'h0000)
        begin
          if (!immediate &&
              fr_r < retry_r[`ARTS_FRMRETRY_MSB:`ARTS_FRMRETRY_LSB])
          begin
            fr_nxt = fr_r + 4'h1;
            nb_nxt = 3'h0;
            be_nxt = minBe;
            st_nxt = arts_pkg::ARTS_BACKOFF;
            symLeft_nxt = backoffSyms(lfsr_r, minBe);
          end
          else
          begin
            st_nxt = arts_pkg::ARTS_IDLE;
            result_nxt = `ARTS_RES_NOACK;
            events[`ARTS_IRQ_FRAMEEND] = 1'b1;
          end
        end
      default:
        st_nxt = arts_pkg::ARTS_OFF;
    endcase

    // A new transmission attempt restarts the fetch from the header.
    if (st_nxt == arts_pkg::ARTS_TX && st_r != arts_pkg::ARTS_TX)
    begin
      fetchIdx_nxt = `ARTS_IDX_PHR;
      sentCnt_nxt = 8'h00;
      lenKnown_nxt = 1'b0;
    end
    if (cmdWr && bus.wdata[`ARTS_CMD_MSB:0] == `ARTS_CMD_FORCEOFF)
    begin
      st_nxt = arts_pkg::ARTS_OFF;
      headV_nxt = 1'b0;
      tailV_nxt = 1'b0;
      fbRd_nxt = 1'b0;
    end

    // Events from neighbouring units, filtered by the transaction.
    if (ev.ccaEdDone && (st_r == arts_pkg::ARTS_OFF ||
                         st_r == arts_pkg::ARTS_IDLE))
      events[`ARTS_IRQ_CCADONE] = 1'b1;
    if (st_r != arts_pkg::ARTS_ACKWAIT)
    begin
      events[`ARTS_IRQ_RXSTART] = ev.rxStart;
      events[`ARTS_IRQ_ADDRMATCH] = ev.addrMatch;
    end
    if (st_r == arts_pkg::ARTS_OFF && aackMode && rx.done &&
        rx.fcsOk && rx.filterMatch)
      events[`ARTS_IRQ_FRAMEEND] = 1'b1;
    irqCause_nxt = events & mask_r;
    irq_nxt = |(events & mask_r);
    ccaRun_nxt = st_nxt == arts_pkg::ARTS_CCA;
    rxOn_nxt = st_nxt == arts_pkg::ARTS_ACKWAIT;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r <= arts_pkg::ARTS_OFF;
      result_r <= `ARTS_RES_OK;
      nb_r <= 3'h0;
      be_r <= 4'h0;
      fr_r <= 4'h0;
      symDiv_r <= 16'h0000;
      symLeft_r <= 16'h0000;
      lfsr_r <= 16'h0001;
      fetchIdx_r <= 8'h00;
      fbAddr_r <= 8'h00;
      sentCnt_r <= 8'h00;
      len_r <= 8'h00;
      fcf_r <= 8'h00;
      seq_r <= 8'h00;
      head_r <= 8'h00;
      tail_r <= 8'h00;
      headV_r <= 1'b0;
      tailV_r <= 1'b0;
      lenKnown_r <= 1'b0;
      fbRd_r <= 1'b0;
      trigPrev_r <= 1'b0;
      ccaRun_r <= 1'b0;
      rxOn_r <= 1'b0;
      irqCause_r <= 8'h00;
      irq_r <= 1'b0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
      result_r <= result_nxt;
      nb_r <= nb_nxt;
      be_r <= be_nxt;
      fr_r <= fr_nxt;
      symDiv_r <= symDiv_nxt;
      symLeft_r <= symLeft_nxt;
      // A zero word would lock the generator up.
      lfsr_r <= (lfsr_nxt == 16'h0000) ? 16'h0001 : lfsr_nxt;
      fetchIdx_r <= fetchIdx_nxt;
      fbAddr_r <= fbAddr_nxt;
      sentCnt_r <= sentCnt_nxt;
      len_r <= len_nxt;
      fcf_r <= fcf_nxt;
      seq_r <= seq_nxt;
      head_r <= head_nxt;
      tail_r <= tail_nxt;
      headV_r <= headV_nxt;
      tailV_r <= tailV_nxt;
      lenKnown_r <= lenKnown_nxt;
      fbRd_r <= fbRd_nxt;
      trigPrev_r <= sleepTrigger;
      ccaRun_r <= ccaRun_nxt;
      rxOn_r <= rxOn_nxt;
      irqCause_r <= irqCause_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign ccaRun = ccaRun_r;
  assign fbRead = fbRd_r;
  assign fbAddr = fbAddr_r;
  assign txData = head_r;
  assign txValid = headV_r;
  assign rxOn = rxOn_r;
  assign irqCause = irqCause_r;
  assign irqLine = irq_r;

endmodule // arts_sequencer

/* testbench/arts_monitor.sv */
// Checker for the retry transmit sequencer, bound to its top module.
// Assumes one clock domain and the design's symbol length parameters.
`timescale 1ns/10ps
module arts_monitor #(
  parameter logic [15:0] SymCyclesBpsk = 16'h0002,
  parameter logic [15:0] SymCyclesOqpsk = 16'h0002
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic oqpskMode,
  input wire logic ccaRun,
  input wire logic fbRead,
  input wire logic [7:0] txData,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic rxOn,
  input wire arts_pkg::arts_rx_t rx,
  input wire logic [7:0] irqCause
);
  int sym, lim, ccaCnt_r, ccaCnt_nxt, ackCnt_r, ackCnt_nxt;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  assign sym = oqpskMode ? int'(SymCyclesOqpsk) : int'(SymCyclesBpsk);
  assign lim = oqpskMode ? 54 * sym : 120 * sym;
  always_comb
  begin
    ccaCnt_nxt = ccaRun ? ccaCnt_r + 1 : 0;
    ackCnt_nxt = rxOn ? ackCnt_r + 1 : 0;
  end
  always_ff @(posedge clk)
  begin
    ccaCnt_r <= rst ? 0 : ccaCnt_nxt;
    ackCnt_r <= rst ? 0 : ackCnt_nxt;
  end
  // ****************************************************************
  // Properties
  // ****************************************************************
  // The first symbol may be short because the symbol tick runs free.
  property p_cca_len;
    $fell(ccaRun) |-> ccaCnt_r > 7 * sym && ccaCnt_r <= 8 * sym + 1;
  endproperty
  a_cca_len: assert property (p_cca_len)
    else $error("CCA window length wrong");
  property p_ack_len;
    rxOn |-> ackCnt_r <= lim + sym + 2;
  endproperty
  a_ack_len: assert property (p_ack_len)
    else $error("ACK wait too long");
  property p_ack_min;
    $fell(rxOn) && !$past(rx.done) |-> ackCnt_r > lim - sym;
  endproperty
  a_ack_min: assert property (p_ack_min)
    else $error("ACK wait too short");
  property p_cca_quiet;
    ccaRun |=> !irqCause[4];
  endproperty
  a_cca_quiet: assert property (p_cca_quiet)
    else $error("CCA done forwarded in transaction");
  property p_wait_quiet;
    rxOn |=> !irqCause[2] && !irqCause[5];
  endproperty
  a_wait_quiet: assert property (p_wait_quiet)
    else $error("receive event forwarded in ACK wait");
  property p_tx_hold;
    txValid && !txReady |=> txValid && $stable(txData);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("byte dropped while stalled");
  property p_cca_first;
    ccaRun |-> !txValid && !rxOn;
  endproperty
  a_cca_first: assert property (p_cca_first)
    else $error("send during CCA");
  property p_fb_idle;
    rxOn |-> !fbRead && !txValid;
  endproperty
  a_fb_idle: assert property (p_fb_idle)
    else $error("buffer used in ACK wait");
  property p_bad_fcs;
    rxOn && rx.done && !rx.fcsOk |=> rxOn;
  endproperty
  a_bad_fcs: assert property (p_bad_fcs)
    else $error("corrupt frame ended ACK wait");
endmodule // arts_monitor
bind arts_sequencer arts_monitor #(.SymCyclesBpsk(SymCyclesBpsk),
  .SymCyclesOqpsk(SymCyclesOqpsk)) u_mon (.clk, .rst, .oqpskMode, .ccaRun,
  .fbRead, .txData, .txValid, .txReady, .rxOn, .rx, .irqCause);

/* testbench/arts_peer_model.sv */
// Far side: a modulator that stalls at random and a peer node replying
// in the ACK wait as mode asks. Assumes the sequencer's port types.
`timescale 1ns/10ps
module arts_peer_model (
  input wire logic clk,
  input wire logic [7:0] txData,
  input wire logic txValid,
  input wire logic rxOn,
  input wire logic [1:0] mode,
  input wire logic busy,
  output logic txReady,
  output logic ccaIdle,
  output arts_pkg::arts_rx_t rx
);
  int s = 32'h3f63;
  int cnt = 0;
  int wt = 0;
  logic [7:0] len = 8'h00;
  logic [7:0] seq = 8'h00;
  initial
  begin
    txReady = 0;
    ccaIdle = 1;
    rx = '0;
  end
  // Mode 3 sends a corrupt frame and a wrong sequence before the good one.
  always @(posedge clk)
  begin
    if (txValid && txReady)
    begin
      if (cnt == 0) len = txData;
      if (cnt == 3) seq = txData;
      cnt = (cnt == int'(len[6:0])) ? 0 : cnt + 1;
    end
    wt = rxOn ? wt + 1 : 0;
    #1;
    txReady = 1'($random(s));
    ccaIdle = !busy;
    rx = arts_pkg::arts_rx_t'(13'($random(s)));
    rx.done = 1'b0;
    if (mode == 2'h3 && wt == 10) rx = {4'hb, 1'b0, seq};
    if (mode == 2'h3 && wt == 14) rx = {4'hf, 1'b0, seq ^ 8'h01};
    if (mode != 2'h0 && wt == 20) rx = {4'hf, mode == 2'h2, seq};
  end
endmodule // arts_peer_model

/* testbench/testbench.sv */
// Self-checking bench for the retry transmit sequencer.
// Assumes arts_pkg, the design and the peer model are compiled first.
`timescale 1ns/10ps
module testbench;
  logic clk = 0, rst = 1, sleepTrigger = 0, oqpskMode = 0, busy = 0;
  logic [1:0] mode = 0;
  arts_pkg::arts_bus_t bus = '0;
  arts_pkg::arts_rx_t rx;
  arts_pkg::arts_ev_t ev = '0;
  logic [7:0] regRdata, fbAddr, txData, irqCause, fb [0:255];
  logic ccaRun, ccaIdle, fbRead, txValid, txReady, rxOn, irqLine, reSeen = 0;
  logic [15:0] rdQ [$];
  logic irqQ [$];
  int nMismatch = 0, checkCount = 0, nEnd = 0, cyc = 0, seed = 32'h3f63;
  int nWait = 0, nIrq = 0;
  arts_sequencer #(.SymCyclesBpsk(16'h0002), .SymCyclesOqpsk(16'h0002)) DUT (
    .clk, .rst, .ce(1'b1), .bus, .regRdata, .sleepTrigger, .oqpskMode,
    .aackMode(1'b0), .ccaRun, .ccaIdle, .fbRead, .fbAddr,
    .fbData(fb[fbAddr]), .txData, .txValid, .txReady, .rxOn, .rx, .ev,
    .irqCause, .irqLine);
  arts_peer_model peer (.clk, .txData, .txValid, .rxOn, .mode, .busy,
    .txReady, .ccaIdle, .rx);
  initial forever #10 clk = ~clk;
  always @(posedge rxOn) nWait++;
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic summarize;
    $display("checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmpRead(input logic [15:0] e);
    checkCount++;
    if ((regRdata & e[7:0]) !== e[15:8])
    begin
      nMismatch++;
      $display("CHECK FAILED %0t read %h", $time, regRdata);
    end
  endtask
  task automatic cmpEnd;
    checkCount++;
    if (irqQ.size() == 0 || irqLine !== 1'b1)
    begin
      nMismatch++;
      $display("CHECK FAILED %0t unexpected frame end", $time);
    end
    else
      void'(irqQ.pop_front());
  endtask
  task automatic cmpCount(input int e, got);
    checkCount++;
    if (got != e)
    begin
      nMismatch++;
      $display("CHECK FAILED %0t count %0d", $time, got);
    end
  endtask
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    bus = {w, !w, a, d};
    @(posedge clk);
    #1;
    bus.we = 0;
    bus.re = 0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e, m);
    rdQ.push_back({e & m, m});
    acc(0, a, 8'h00);
  endtask
  task automatic run(input logic [7:0] fcf, rl, input logic [1:0] m,
    input logic b, pin, input logic [2:0] res, input int nt);
    int k, w;
    fb[1] = fcf;
    fb[3] = 8'($random(seed));
    oqpskMode = 1'($random(seed));
    acc(1, 6'h2c, rl);
    mode = m;
    busy = b;
    irqQ.push_back(1'b1);
    k = nEnd;
    w = nWait;
    if (pin) sleepTrigger = 1;
    else acc(1, 6'h02, 8'h02);
    rd(6'h01, 8'h12, 8'h1f);
    if (m == 2'h0 && fcf[5])
    begin
      for (int i = 0; i < 400 && rxOn !== 1'b1; i++) @(posedge clk);
      rd(6'h02, 8'h40, 8'he0);
    end
    for (int i = 0; i < 3000 && nEnd == k; i++) @(posedge clk);
    cmpCount(nt, nWait - w);
    rd(6'h02, {res, 5'h00}, 8'he0);
    rd(6'h01, 8'h19, 8'h1f);
    sleepTrigger = 0;
  endtask
  // ****************************************************************
  // Watchers and main sequence
  // ****************************************************************
  always @(posedge clk)
  begin
    #1;
    ev = 3'($random(seed));
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (!rst && irqLine !== 1'b0) nIrq++;
    if (reSeen) cmpRead(rdQ.pop_front());
    if (irqCause[3] === 1'b1)
    begin
      nEnd <= nEnd + 1;
      cmpEnd();
    end
    reSeen <= bus.re;
    if (cyc > 12000)
    begin
      nMismatch++;
      summarize();
    end
  end
  initial
  begin
    for (int i = 0; i < 256; i++) fb[i] = 8'($random(seed));
    fb[0] = 8'h05;
    repeat (6) @(posedge clk);
    #1;
    rst = 0;
    rd(6'h2c, 8'h38, 8'hff);
    rd(6'h04, 8'h20, 8'hff);
    rd(6'h3f, 8'h00, 8'hff);
    cmpCount(0, nIrq);
    acc(1, 6'h0e, 8'h3c);
    acc(1, 6'h02, 8'h19);
    rd(6'h01, 8'h19, 8'h1f);
    rd(6'h02, 8'he0, 8'he0);
    run(8'h01, 8'h00, 2'h0, 0, 1, 3'h0, 0);
    run(8'h21, 8'h00, 2'h1, 0, 0, 3'h0, 1);
    run(8'h21, 8'h00, 2'h2, 0, 1, 3'h1, 1);
    run(8'h21, 8'h00, 2'h3, 0, 0, 3'h0, 1);
    run(8'h21, 8'h10, 2'h0, 0, 0, 3'h5, 2);
    run(8'h21, 8'h10, 2'h0, 0, 1, 3'h5, 2);
    run(8'h21, 8'h02, 2'h1, 1, 0, 3'h3, 0);
    run(8'h21, 8'h3e, 2'h0, 1, 1, 3'h5, 1);
    summarize();
  end
endmodule // testbench
